/* ppr_pkg.sv */
// package for the peripheral output pin remap block: register map, fields, reset values
// assumes a single 40 MHz clock domain and an AHB-Lite register bus with 32-bit data
package ppr_pkg;
	// register byte offsets
	localparam logic [7:0] PPR_OFS_PAIR_14 = 8'h00;
	localparam logic [7:0] PPR_OFS_PAIR_15 = 8'h04;
	localparam logic [7:0] PPR_OFS_ALT_SEL = 8'h08;
	// field layout of an output remap register
	localparam int PPR_FUNC_W = 6;
	localparam int PPR_LO_FIELD_LSB = 0;
	localparam int PPR_HI_FIELD_LSB = 8;
	// alternate clock pin select bit
	localparam int PPR_ALT_FORCE_BIT = 0;
	// reset values
	localparam logic [5:0] PPR_FUNC_RST = 6'h00;
	localparam logic PPR_FORCE_RST = 1'b0;
	// function number that means no peripheral is connected
	localparam logic [5:0] PPR_FUNC_NONE = 6'h00;
	// function number of the first spi clock output
	localparam logic [5:0] PPR_SPI1_CLK_FUNC = 6'h08;
	// remappable pins handled here: 28, 29, 30, 31
	localparam int PPR_NUM_PINS = 4;
	localparam int PPR_PIN28 = 0;
	localparam int PPR_PIN29 = 1;
	localparam int PPR_PIN30 = 2;
	localparam int PPR_PIN31 = 3;
	// ahb transfer type and response
	localparam logic [1:0] PPR_HTRANS_NONSEQ = 2'h2;
	localparam logic PPR_HRESP_OKAY = 1'b0;
endpackage

/* ppr_func_select.sv */
// one remappable pin: picks the peripheral output named by a function number
// assumes function outputs arrive as a flat vector indexed by function number
module ppr_func_select #(
	parameter int NUM_FUNC = 64
) (
	input wire logic [ppr_pkg::PPR_FUNC_W-1:0] i_func_sel,
	input wire logic [NUM_FUNC-1:0] i_periph_out,
	input wire logic i_block_spi_clk,
	output logic o_pin_value,
	output logic o_pin_enable
);
	import ppr_pkg::*;

	// function zero drives nothing; a blocked spi clock is dropped as if unmapped
	always_comb begin
		o_pin_value = 1'b0;
		o_pin_enable = 1'b0;
		if (i_func_sel != PPR_FUNC_NONE && 32'(i_func_sel) < NUM_FUNC &&
				!(i_block_spi_clk && i_func_sel == PPR_SPI1_CLK_FUNC)) begin
			o_pin_value = i_periph_out[i_func_sel];
			o_pin_enable = 1'b1;
		end
	end
endmodule

/* ppr_remap_out.sv */
// peripheral output pin remap for pins 28 to 31 with an ahb-lite register slave
// assumes one clock, synchronous peripheral outputs and one bus master
//
// Operation
// - pin 29 carries the function chosen by bits 13..8 of remap pair 14.
// - pin 28 carries the function chosen by bits 5..0 of remap pair 14.
// - pin 31 carries the function chosen by bits 13..8 of remap pair 15.
// - pin 30 carries the function chosen by bits 5..0 of remap pair 15.
// - on 64- and 80-pin variants the pin 31 field is absent, reads zero.
// - unused bits of alternate select and remap registers always read zero.
// - alternate select bit set: spi1 clock goes to dedicated pin only.
// - alternate select bit clear: spi1 clock goes only where remap fields select.
module ppr_remap_out #(
	parameter int NUM_FUNC = 64,
	parameter bit PIN31_PRESENT = 1'b1
) (
	input wire logic i_ref_clk,
	input wire logic i_reset,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	input wire logic [NUM_FUNC-1:0] i_periph_out,
	output logic [ppr_pkg::PPR_NUM_PINS-1:0] o_pin_out,
	output logic [ppr_pkg::PPR_NUM_PINS-1:0] o_pin_oe,
	output logic o_dedicated_spi1_clock_pin,
	output logic o_dedicated_spi1_clock_pin_oe
);
	import ppr_pkg::*;

	logic ph_wr_q, ph_wr_d;
	logic ph_rd_q, ph_rd_d;
	logic [7:0] ph_addr_q, ph_addr_d;
	logic [PPR_FUNC_W-1:0] func_q [PPR_NUM_PINS];
	logic [PPR_FUNC_W-1:0] func_d [PPR_NUM_PINS];
	logic spi1_clock_alt_pin_force_q, spi1_clock_alt_pin_force_d;
	logic [15:0] pin_remap_out_pair_14, pin_remap_out_pair_15, alternate_clock_pin_select;
	logic [PPR_NUM_PINS-1:0] sel_value, sel_enable;
	logic [PPR_NUM_PINS-1:0] pin_out_q, pin_out_d, pin_oe_q, pin_oe_d;
	logic alt_out_q, alt_out_d, alt_oe_q, alt_oe_d;
	logic addr_take;
	logic [31:0] hrdata_q, hrdata_d;

	// zero wait states, so the slave is always ready and always answers okay
	assign o_hreadyout = 1'b1;
	assign o_hresp = PPR_HRESP_OKAY;
	assign addr_take = i_hsel && i_hready && i_htrans[1];

	// address phase capture; sequential htrans is treated like nonseq
	always_comb begin
		ph_wr_d = addr_take && i_hwrite;
		ph_rd_d = addr_take && !i_hwrite;
		ph_addr_d = addr_take ? i_haddr[7:0] : ph_addr_q;
	end

	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			ph_wr_q <= 1'b0;
			ph_rd_q <= 1'b0;
			ph_addr_q <= 8'h00;
		end else begin
			ph_wr_q <= ph_wr_d;
			ph_rd_q <= ph_rd_d;
			ph_addr_q <= ph_addr_d;
		end
	end

	// register writes land at the end of the data phase; unmapped writes are dropped
	always_comb begin
		for (int k = 0; k < PPR_NUM_PINS; k++) begin
			func_d[k] = func_q[k];
		end
		spi1_clock_alt_pin_force_d = spi1_clock_alt_pin_force_q;
		if (ph_wr_q) begin
			case (ph_addr_q)
				PPR_OFS_PAIR_14: begin
					func_d[PPR_PIN28] = i_hwdata[PPR_LO_FIELD_LSB +: PPR_FUNC_W];
					func_d[PPR_PIN29] = i_hwdata[PPR_HI_FIELD_LSB +: PPR_FUNC_W];
				end
				PPR_OFS_PAIR_15: begin
					func_d[PPR_PIN30] = i_hwdata[PPR_LO_FIELD_LSB +: PPR_FUNC_W];
					// the smaller packages have no pin 31, so its field never stores
					if (PIN31_PRESENT) begin
						func_d[PPR_PIN31] = i_hwdata[PPR_HI_FIELD_LSB +: PPR_FUNC_W];
					end
				end
				PPR_OFS_ALT_SEL: begin
					spi1_clock_alt_pin_force_d = i_hwdata[PPR_ALT_FORCE_BIT];
				end
				default: begin
				end
			endcase
		end
	end

	// mapping state clears to no function and no forcing
	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			for (int k = 0; k < PPR_NUM_PINS; k++) begin
				func_q[k] <= PPR_FUNC_RST;
			end
			spi1_clock_alt_pin_force_q <= PPR_FORCE_RST;
		end else begin
			for (int k = 0; k < PPR_NUM_PINS; k++) begin
				func_q[k] <= func_d[k];
			end
			spi1_clock_alt_pin_force_q <= spi1_clock_alt_pin_force_d;
		end
	end

	// read views of the next state, so a read right behind a write sees the new value
	assign pin_remap_out_pair_14 = {2'b00, func_d[PPR_PIN29], 2'b00, func_d[PPR_PIN28]};
	assign pin_remap_out_pair_15 = {2'b00, func_d[PPR_PIN31], 2'b00, func_d[PPR_PIN30]};
	assign alternate_clock_pin_select = {15'h0, spi1_clock_alt_pin_force_d};

	// read data is caught at the address phase and stands through the data phase only;
	// flopping it costs no wait state and keeps the bus output free of decode glitches
	always_comb begin
		hrdata_d = 32'h00000000;
		if (addr_take && !i_hwrite) begin
			case (i_haddr[7:0])
				PPR_OFS_PAIR_14: hrdata_d = {16'h0000, pin_remap_out_pair_14};
				PPR_OFS_PAIR_15: hrdata_d = {16'h0000, pin_remap_out_pair_15};
				PPR_OFS_ALT_SEL: hrdata_d = {16'h0000, alternate_clock_pin_select};
				default: hrdata_d = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			hrdata_q <= 32'h00000000;
		end else begin
			hrdata_q <= hrdata_d;
		end
	end

	assign o_hrdata = hrdata_q;

	// one selector per pin; forcing blocks the spi1 clock from every remapped pin
	genvar g;
	generate
		for (g = 0; g < PPR_NUM_PINS; g++) begin : g_pin
			ppr_func_select #(
				.NUM_FUNC(NUM_FUNC)
			) u_sel (
				.i_func_sel(func_q[g]),
				.i_periph_out(i_periph_out),
				.i_block_spi_clk(spi1_clock_alt_pin_force_q),
				.o_pin_value(sel_value[g]),
				.o_pin_enable(sel_enable[g])
			);
		end
	endgenerate

	// pin drive and dedicated clock pin, registered to keep pin timing clean
	always_comb begin
		pin_out_d = sel_value;
		pin_oe_d = sel_enable;
		alt_out_d = spi1_clock_alt_pin_force_q && i_periph_out[PPR_SPI1_CLK_FUNC];
		alt_oe_d = spi1_clock_alt_pin_force_q;
	end

	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			pin_out_q <= '0;
			pin_oe_q <= '0;
			alt_out_q <= 1'b0;
			alt_oe_q <= 1'b0;
		end else begin
			pin_out_q <= pin_out_d;
			pin_oe_q <= pin_oe_d;
			alt_out_q <= alt_out_d;
			alt_oe_q <= alt_oe_d;
		end
	end

	assign o_pin_out = pin_out_q;
	assign o_pin_oe = pin_oe_q;
	assign o_dedicated_spi1_clock_pin = alt_out_q;
	assign o_dedicated_spi1_clock_pin_oe = alt_oe_q;

	// checks on routing, register contents and reset
	pin29_route_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(func_q[PPR_PIN29] != PPR_FUNC_NONE && func_q[PPR_PIN29] != PPR_SPI1_CLK_FUNC)
		|=> (o_pin_oe[PPR_PIN29] && o_pin_out[PPR_PIN29] == $past(i_periph_out[func_q[PPR_PIN29]])))
		else $error("pin 29 does not follow its function number");

	pin28_write_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(ph_wr_q && ph_addr_q == PPR_OFS_PAIR_14 && i_hwdata[5:0] != PPR_FUNC_NONE
			&& i_hwdata[5:0] != PPR_SPI1_CLK_FUNC)
		|=> ##1 (o_pin_oe[PPR_PIN28] || func_q[PPR_PIN28] != $past(i_hwdata[5:0], 2)))
		else $error("pin 28 not driven two cycles after its field was written");

	pin31_route_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(func_q[PPR_PIN31] != PPR_FUNC_NONE && func_q[PPR_PIN31] != PPR_SPI1_CLK_FUNC)
		|=> (o_pin_oe[PPR_PIN31] && o_pin_out[PPR_PIN31] == $past(i_periph_out[func_q[PPR_PIN31]])))
		else $error("pin 31 does not follow its function number");

	pin30_route_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(func_q[PPR_PIN30] != PPR_FUNC_NONE && func_q[PPR_PIN30] != PPR_SPI1_CLK_FUNC)
		|=> (o_pin_oe[PPR_PIN30] && o_pin_out[PPR_PIN30] == $past(i_periph_out[func_q[PPR_PIN30]])))
		else $error("pin 30 does not follow its function number");

	pin31_absent_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		!PIN31_PRESENT |-> (func_q[PPR_PIN31] == PPR_FUNC_NONE && !o_pin_oe[PPR_PIN31]))
		else $error("pin 31 field holds a value in a package without pin 31");

	reserved_zero_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		ph_rd_q |-> (o_hrdata[31:16] == 16'h0000 && o_hrdata[15:14] == 2'b00 && o_hrdata[7:6] == 2'b00
			&& (ph_addr_q != PPR_OFS_ALT_SEL || o_hrdata[15:1] == 15'h0)))
		else $error("unimplemented register bits read as nonzero");

	alt_clk_force_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		spi1_clock_alt_pin_force_q [*2] |-> (o_dedicated_spi1_clock_pin_oe
			&& o_dedicated_spi1_clock_pin == $past(i_periph_out[PPR_SPI1_CLK_FUNC])
			&& !(o_pin_oe[PPR_PIN28] && $past(func_q[PPR_PIN28]) == PPR_SPI1_CLK_FUNC)))
		else $error("forced spi1 clock not on the dedicated pin only");

	remap_clk_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(!spi1_clock_alt_pin_force_q && func_q[PPR_PIN30] == PPR_SPI1_CLK_FUNC)
		|=> (!o_dedicated_spi1_clock_pin_oe && o_pin_oe[PPR_PIN30]
			&& o_pin_out[PPR_PIN30] == $past(i_periph_out[PPR_SPI1_CLK_FUNC])))
		else $error("unforced spi1 clock not routed by the remap field");

	reset_clear_a: assert property (@(posedge i_ref_clk)
		$past(i_reset) |-> (func_q[PPR_PIN28] == PPR_FUNC_RST && func_q[PPR_PIN29] == PPR_FUNC_RST
			&& func_q[PPR_PIN30] == PPR_FUNC_RST && !spi1_clock_alt_pin_force_q && o_pin_oe == '0))
		else $error("mapping state not clear after reset");

	func_none_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(func_q[PPR_PIN30] == PPR_FUNC_NONE) |=> !o_pin_oe[PPR_PIN30])
		else $error("function zero drove pin 30");

	pin29_none_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(func_q[PPR_PIN29] == PPR_FUNC_NONE) |=> !o_pin_oe[PPR_PIN29])
		else $error("function zero drove pin 29");

	pin28_none_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(func_q[PPR_PIN28] == PPR_FUNC_NONE) |=> !o_pin_oe[PPR_PIN28])
		else $error("function zero drove pin 28");

	pin28_route_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(func_q[PPR_PIN28] != PPR_FUNC_NONE && func_q[PPR_PIN28] != PPR_SPI1_CLK_FUNC)
		|=> (o_pin_oe[PPR_PIN28] && o_pin_out[PPR_PIN28] == $past(i_periph_out[func_q[PPR_PIN28]])))
		else $error("pin 28 does not follow its function number");

	// stores: each field takes the data-phase word at the edge that closes the write
	pin29_store_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(ph_wr_q && ph_addr_q == PPR_OFS_PAIR_14)
		|=> func_q[PPR_PIN29] == $past(i_hwdata[PPR_HI_FIELD_LSB +: PPR_FUNC_W]))
		else $error("pin 29 field did not take the written value");

	pin28_store_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(ph_wr_q && ph_addr_q == PPR_OFS_PAIR_14)
		|=> func_q[PPR_PIN28] == $past(i_hwdata[PPR_LO_FIELD_LSB +: PPR_FUNC_W]))
		else $error("pin 28 field did not take the written value");

	pin31_store_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(PIN31_PRESENT && ph_wr_q && ph_addr_q == PPR_OFS_PAIR_15)
		|=> func_q[PPR_PIN31] == $past(i_hwdata[PPR_HI_FIELD_LSB +: PPR_FUNC_W]))
		else $error("pin 31 field did not take the written value");

	pin30_store_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(ph_wr_q && ph_addr_q == PPR_OFS_PAIR_15)
		|=> func_q[PPR_PIN30] == $past(i_hwdata[PPR_LO_FIELD_LSB +: PPR_FUNC_W]))
		else $error("pin 30 field did not take the written value");

	alt_store_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(ph_wr_q && ph_addr_q == PPR_OFS_ALT_SEL)
		|=> spi1_clock_alt_pin_force_q == $past(i_hwdata[PPR_ALT_FORCE_BIT]))
		else $error("alternate select bit did not take the written value");

	// reads: the data phase shows the fields as they stand in that cycle
	pair14_read_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(ph_rd_q && ph_addr_q == PPR_OFS_PAIR_14)
		|-> (o_hrdata[13:8] == func_q[PPR_PIN29] && o_hrdata[5:0] == func_q[PPR_PIN28]))
		else $error("remap pair 14 read does not show its fields");

	pair15_read_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(ph_rd_q && ph_addr_q == PPR_OFS_PAIR_15)
		|-> (o_hrdata[13:8] == func_q[PPR_PIN31] && o_hrdata[5:0] == func_q[PPR_PIN30]))
		else $error("remap pair 15 read does not show its fields");

	pin31_read_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(!PIN31_PRESENT && ph_rd_q && ph_addr_q == PPR_OFS_PAIR_15) |-> o_hrdata[13:8] == 6'h00)
		else $error("absent pin 31 field reads nonzero");

	// spi1 clock steering: the dedicated pin is dark unless forced, a forced clock leaves the remap
	alt_idle_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		!spi1_clock_alt_pin_force_q |=> (!o_dedicated_spi1_clock_pin_oe && !o_dedicated_spi1_clock_pin))
		else $error("dedicated clock pin driven while not forced");

	force_block_a: assert property (@(posedge i_ref_clk) disable iff (i_reset)
		(spi1_clock_alt_pin_force_q && func_q[PPR_PIN30] == PPR_SPI1_CLK_FUNC)
		|=> (!o_pin_oe[PPR_PIN30] && !o_pin_out[PPR_PIN30]))
		else $error("forced spi1 clock still on remapped pin 30");
endmodule

/* ppr_periph_model.sv */
// partner model: the peripheral output functions that feed the pin remap block
// assumes one clock; the bench sets the pattern, the model launches it on the next edge
module ppr_periph_model #(
	parameter int NUM_FUNC = 64
) (
	input wire logic i_ref_clk,
	input wire logic [NUM_FUNC-1:0] i_pattern,
	output logic [NUM_FUNC-1:0] o_periph_out
);
	timeunit 1ns;
	timeprecision 1ps;

	// registered like a real peripheral, so outputs never change off the clock edge
	always_ff @(posedge i_ref_clk) begin
		o_periph_out <= i_pattern;
	end
endmodule

/* peripheral_output_pin_remap_tb.sv */
// testbench: ahb-lite register accesses and pin checks for the output pin remap block
// assumes a zero-wait slave; a second instance models the package without pin 31
module peripheral_output_pin_remap_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import ppr_pkg::*;
	logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hready, hresp, hready2, hresp2;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, hrdata2, rdv, rdv2;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2; // word access only
	logic [63:0] pat = 64'h0, periph;
	logic [3:0] pin, oe, pin2, oe2;
	logic dpin, doe, dpin2, doe2;
	int num_errors = 0, compares = 0;
	// clock generator
	initial begin
		forever #12.5 clk = ~clk;
	end
	ppr_periph_model ppr_periph_model_inst (.i_ref_clk(clk), .i_pattern(pat), .o_periph_out(periph));
	ppr_remap_out ppr_remap_out_inst (.i_ref_clk(clk), .i_reset(rst), .i_hsel(hsel), .i_haddr(haddr),
		.i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
		.o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp), .i_periph_out(periph), .o_pin_out(pin),
		.o_pin_oe(oe), .o_dedicated_spi1_clock_pin(dpin), .o_dedicated_spi1_clock_pin_oe(doe));
	// small package variant shares the bus; only its read data, response, ready and pins are looked at
	ppr_remap_out #(.PIN31_PRESENT(1'b0)) ppr_remap_out_inst2 (.i_ref_clk(clk), .i_reset(rst), .i_hsel(hsel),
		.i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
		.i_hready(hready), .o_hrdata(hrdata2), .o_hreadyout(hready2), .o_hresp(hresp2),
		.i_periph_out(periph), .o_pin_out(pin2), .o_pin_oe(oe2), .o_dedicated_spi1_clock_pin(dpin2),
		.o_dedicated_spi1_clock_pin_oe(doe2));
	task tally_and_finish;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// bounded wait for hready at a rising edge; a hang ends the run
	task wait_rdy;
		int n;
		n = 0;
		@(posedge clk);
		while (hready !== 1'b1) begin
			n++;
			if (n > 50) begin
				num_errors++;
				tally_and_finish;
			end
			@(posedge clk);
		end
	endtask
	// one single transfer: address phase, then data phase; read data taken at the closing edge
	// starts on a fresh rising edge so every request is launched right after the clock
	task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= PPR_HTRANS_NONSEQ;
		haddr <= {24'h00, a};
		hwrite <= w;
		wait_rdy;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy;
		rdv = hrdata;
		rdv2 = hrdata2;
	endtask
	// pins lag the register write and the pattern by a few registered stages
	task settle;
		repeat (4) @(posedge clk);
		#1;
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		// every register and the unmapped word read zero after reset
		for (int i = 0; i < 4; i++) begin
			ahb(1'b0, 8'(4 * i), 32'h0);
			check(rdv, 32'h0);
			check(32'({hresp, hresp2, hready2}), 32'({PPR_HRESP_OKAY, PPR_HRESP_OKAY, 1'b1}));
		end
		ahb(1'b1, 8'h0C, 32'hFFFF_FFFF);
		ahb(1'b0, 8'h0C, 32'h0);
		check(rdv, 32'h0);
		ahb(1'b1, PPR_OFS_PAIR_14, 32'hFFFF_FFFF);
		ahb(1'b0, PPR_OFS_PAIR_14, 32'h0);
		check(rdv, 32'h0000_3F3F);
		ahb(1'b1, PPR_OFS_PAIR_15, 32'hFFFF_FFFF);
		ahb(1'b0, PPR_OFS_PAIR_15, 32'h0);
		check(rdv, 32'h0000_3F3F);
		check(rdv2, 32'h0000_003F);
		ahb(1'b1, PPR_OFS_ALT_SEL, 32'hFFFF_FFFF);
		ahb(1'b0, PPR_OFS_ALT_SEL, 32'h0);
		check(rdv, 32'h0000_0001);
		ahb(1'b1, PPR_OFS_ALT_SEL, 32'h0);
		// four distinct functions, pattern and its inverse so each pin shows both levels
		ahb(1'b1, PPR_OFS_PAIR_14, 32'h0000_0503);
		ahb(1'b1, PPR_OFS_PAIR_15, 32'h0000_090C);
		pat <= 64'hA5C3_0F96_5A3C_E529;
		for (int k = 0; k < 2; k++) begin
			settle;
			check(32'(pin), 32'({pat[9], pat[12], pat[5], pat[3]}));
			check(32'(oe), 32'hF);
			check(32'(oe2[3]), 32'h0);
			check(32'({oe2[2:0], pin2[2:0]}), 32'({3'h7, pat[12], pat[5], pat[3]}));
			@(posedge clk);
			pat <= ~pat;
		end
		// function zero leaves the pin undriven
		ahb(1'b1, PPR_OFS_PAIR_14, 32'h0000_0500);
		settle;
		check(32'(oe[0]), 32'h0);
		// spi1 clock on pin 30, then forced to its dedicated pin
		ahb(1'b1, PPR_OFS_PAIR_15, 32'h0000_0900 | 32'(PPR_SPI1_CLK_FUNC));
		settle;
		check(32'({oe[2], pin[2], doe}), 32'({1'b1, pat[8], 1'b0}));
		ahb(1'b1, PPR_OFS_ALT_SEL, 32'h1);
		settle;
		check(32'({oe[2], doe, dpin}), 32'({1'b0, 1'b1, pat[8]}));
		check(32'({oe2[2], doe2, dpin2}), 32'({1'b0, 1'b1, pat[8]}));
		// reset in mid-run clears the mapping again
		@(posedge clk);
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		ahb(1'b0, PPR_OFS_PAIR_15, 32'h0);
		check(rdv, 32'h0);
		check(32'({oe, doe}), 32'h0);
		tally_and_finish;
	end
endmodule
